/* File: rtl/sdac_control.sv */
// sigma-delta converter control: registers, clocking, calibration and filter selection
`timescale 1ns/1ps
module sdac_control
  import sdac_pkg::*;
#(
  parameter int DEC_WIDTH = 11
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire sdac_sfr_req_type i_sfr,
  input wire logic [DEC_WIDTH-1:0] i_decimation_ratio,
  input wire logic [7:0] i_current_source_code,
  input wire logic i_channel_change,
  input wire logic [23:0] i_raw_result,
  input wire logic i_result_read,
  output logic [7:0] o_sfr_rdata,
  output sdac_analog_type o_analog,
  output logic o_modulator_tick,
  output logic o_conversion_tick,
  output logic o_settled,
  output logic o_cal_busy,
  output logic o_adc_interrupt,
  output logic [23:0] o_offset_correction,
  output logic [23:0] o_gain_correction
);

  logic [7:0] ctrl0_reg; // reference, buffer and burnout controls
  logic [7:0] ctrl1_reg; // filter and calibration command
  logic [7:0] trim_reg; // offset trim code
  logic [7:0] aclk_reg; // analog clock divider
  logic [7:0] div_reg; // first divider stage
  logic [5:0] mod_reg; // divide-by-64 stage
  logic [DEC_WIDTH-1:0] dec_reg; // modulator periods in this conversion
  logic mod_tick_reg; // internal modulator period strobe
  logic conv_tick_reg; // internal conversion strobe
  sdac_state_type state_reg; // calibration sequencer
  sdac_cal_type cal_code_reg; // command being run
  logic [3:0] cal_count_reg; // conversions spent in this step
  logic [1:0] auto_stage_reg; // conversions since a channel change, saturating
  logic [1:0] settle_reg; // conversions since a change, saturating
  logic irq_reg; // interrupt flag
  logic cal_done; // last conversion of the last step
  logic step_end; // last conversion of any step
  logic wr_ctrl1; // command write strobe
  logic cal_start; // accepted command
  logic [1:0] settle_need; // conversions needed for the active filter
  sdac_filter_type filt_mode; // configured filter mode
  sdac_filter_type filt_now; // filter applied to the current conversion
  logic discard_now; // current conversion is to be thrown away

  assign wr_ctrl1 = i_sfr.wr && (i_sfr.addr == SDAC_ADDR_CTRL1);
  assign filt_mode = sdac_filter_type'(ctrl1_reg[SDAC_C1_FILT_LSB +: 2]);
  // a reserved or empty code never starts a run
  assign cal_start = wr_ctrl1 && (state_reg == SDAC_ST_IDLE) &&
    (i_sfr.wdata[SDAC_C1_CAL_LSB +: 3] != SDAC_CAL_NONE) &&
    (i_sfr.wdata[SDAC_C1_CAL_LSB +: 3] != SDAC_CAL_RSVD);
  assign step_end = conv_tick_reg && (cal_count_reg == SDAC_CAL_PERIODS - 4'h1);
  assign cal_done = step_end && ((state_reg == SDAC_ST_GAIN) ||
    ((state_reg == SDAC_ST_OFFSET) && (cal_code_reg != SDAC_CAL_SELF_BOTH) &&
    (cal_code_reg != SDAC_CAL_SYS_BOTH)));

  // register writes; the command field clears itself when the run ends
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl0_reg <= SDAC_CTRL0_RESET;
      ctrl1_reg <= SDAC_CTRL1_RESET;
      trim_reg <= SDAC_TRIM_RESET;
      aclk_reg <= SDAC_ACLK_RESET;
    end else begin
      if (i_sfr.wr && (i_sfr.addr == SDAC_ADDR_CTRL0)) begin
        ctrl0_reg <= i_sfr.wdata;
      end
      if (i_sfr.wr && (i_sfr.addr == SDAC_ADDR_TRIM)) begin
        trim_reg <= i_sfr.wdata;
      end
      if (i_sfr.wr && (i_sfr.addr == SDAC_ADDR_ACLK)) begin
        aclk_reg <= i_sfr.wdata;
      end
      if (wr_ctrl1) begin
        // a command written while busy is dropped so the run stays coherent
        ctrl1_reg[SDAC_C1_FILT_LSB +: 2] <= i_sfr.wdata[SDAC_C1_FILT_LSB +: 2];
        if (state_reg == SDAC_ST_IDLE) begin
          ctrl1_reg[SDAC_C1_CAL_LSB +: 3] <= i_sfr.wdata[SDAC_C1_CAL_LSB +: 3];
        end
      end
      // kept apart from writes so that a busy write cannot leave a stale code behind
      if (cal_done) begin
        ctrl1_reg[SDAC_C1_CAL_LSB +: 3] <= SDAC_CAL_NONE;
      end
    end
  end

  // register reads, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr.rd) begin
      unique case (i_sfr.addr)
        SDAC_ADDR_CTRL0: o_sfr_rdata <= ctrl0_reg;
        SDAC_ADDR_CTRL1: o_sfr_rdata <= ctrl1_reg;
        SDAC_ADDR_TRIM: o_sfr_rdata <= trim_reg;
        SDAC_ADDR_ACLK: o_sfr_rdata <= aclk_reg;
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // clock chain: divide by divider+1, then by 64, then by the decimation ratio
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      div_reg <= 8'h00;
      mod_reg <= 6'h00;
      dec_reg <= '0;
      mod_tick_reg <= 1'b0;
      conv_tick_reg <= 1'b0;
    end else begin
      mod_tick_reg <= 1'b0;
      conv_tick_reg <= 1'b0;
      if (div_reg >= aclk_reg) begin
        div_reg <= 8'h00;
        if (mod_reg == SDAC_MOD_LAST) begin
          mod_reg <= 6'h00;
          mod_tick_reg <= 1'b1;
          // ratio of zero or one gives a result every modulator period
          if (dec_reg + DEC_WIDTH'(1) >= i_decimation_ratio) begin
            dec_reg <= '0;
            conv_tick_reg <= 1'b1;
          end else begin
            dec_reg <= dec_reg + DEC_WIDTH'(1);
          end
        end else begin
          mod_reg <= mod_reg + 6'h01;
        end
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  // calibration sequencer
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= SDAC_ST_IDLE;
      cal_code_reg <= SDAC_CAL_NONE;
      cal_count_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        SDAC_ST_IDLE: begin
          cal_count_reg <= 4'h0;
          if (cal_start) begin
            cal_code_reg <= sdac_cal_type'(i_sfr.wdata[SDAC_C1_CAL_LSB +: 3]);
            if ((i_sfr.wdata[SDAC_C1_CAL_LSB +: 3] == SDAC_CAL_SELF_GAIN) ||
                (i_sfr.wdata[SDAC_C1_CAL_LSB +: 3] == SDAC_CAL_SYS_GAIN)) begin
              state_reg <= SDAC_ST_GAIN;
            end else begin
              state_reg <= SDAC_ST_OFFSET;
            end
          end
        end
        SDAC_ST_OFFSET: begin
          if (step_end) begin
            cal_count_reg <= 4'h0;
            state_reg <= cal_done ? SDAC_ST_IDLE : SDAC_ST_GAIN;
          end else if (conv_tick_reg) begin
            cal_count_reg <= cal_count_reg + 4'h1;
          end
        end
        SDAC_ST_GAIN: begin
          if (step_end) begin
            cal_count_reg <= 4'h0;
            state_reg <= SDAC_ST_IDLE;
          end else if (conv_tick_reg) begin
            cal_count_reg <= cal_count_reg + 4'h1;
          end
        end
        default: state_reg <= SDAC_ST_IDLE;
      endcase
    end
  end

  // correction values; the measurement already includes the trim offset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_offset_correction <= 24'h000000;
      o_gain_correction <= 24'h000000;
    end else if (step_end && (state_reg == SDAC_ST_OFFSET)) begin
      o_offset_correction <= 24'h000000 - i_raw_result;
    end else if (step_end && (state_reg == SDAC_ST_GAIN)) begin
      o_gain_correction <= SDAC_FULL_SCALE - i_raw_result;
    end
  end

  // auto filter stage and settling counters, restarted by a channel or gain change
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      auto_stage_reg <= 2'h0;
      settle_reg <= 2'h0;
    end else if (i_channel_change) begin
      auto_stage_reg <= 2'h0;
      settle_reg <= 2'h0;
    end else if (conv_tick_reg) begin
      if (auto_stage_reg != 2'h3) begin
        auto_stage_reg <= auto_stage_reg + 2'h1;
      end
      if (settle_reg != 2'h3) begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // filter for the conversion now running
  always_comb begin
    filt_now = filt_mode;
    discard_now = 1'b0;
    if (filt_mode == SDAC_FILT_AUTO) begin
      unique case (auto_stage_reg)
        2'h0: begin
          filt_now = SDAC_FILT_FAST;
          discard_now = 1'b1;
        end
        2'h1: filt_now = SDAC_FILT_FAST;
        2'h2: filt_now = SDAC_FILT_SINC2;
        2'h3: filt_now = SDAC_FILT_SINC3;
      endcase
    end
  end

  // settling length of the applied filter; auto mode is settled by its stage count instead
  always_comb begin
    unique case (filt_now)
      SDAC_FILT_SINC3: settle_need = SDAC_SETTLE_SINC3;
      SDAC_FILT_SINC2: settle_need = SDAC_SETTLE_SINC2;
      default: settle_need = SDAC_SETTLE_FAST;
    endcase
  end

  // front end settings, all from flops
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_analog <= '0;
    end else begin
      o_analog.trim_negative <= trim_reg[SDAC_TRIM_SIGN];
      o_analog.trim_magnitude <= trim_reg[SDAC_TRIM_SIGN-1:0];
      o_analog.buffer_enable <= ctrl0_reg[SDAC_C0_BUFFER];
      o_analog.burnout_detect_enable <= ctrl0_reg[SDAC_C0_BURNOUT];
      o_analog.ref_external <= ctrl0_reg[SDAC_C0_REF_EXT];
      o_analog.ref_enable <= ctrl0_reg[SDAC_C0_REF_EN];
      o_analog.ref_high <= ctrl0_reg[SDAC_C0_REF_HIGH];
      o_analog.current_source_code <= i_current_source_code;
      o_analog.filter_select <= filt_now;
      o_analog.discard <= discard_now;
      // self steps route an internal zero or full-scale; system steps use the pins
      if (state_reg != SDAC_ST_IDLE && cal_code_reg inside
          {SDAC_CAL_SELF_BOTH, SDAC_CAL_SELF_OFFSET, SDAC_CAL_SELF_GAIN}) begin
        o_analog.cal_input_select <= (state_reg == SDAC_ST_GAIN) ?
          SDAC_IN_SELF_FULL : SDAC_IN_SELF_ZERO;
      end else begin
        o_analog.cal_input_select <= SDAC_IN_NORMAL;
      end
    end
  end

  // status strobes and the interrupt flag; a new event wins over a read
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_reg <= 1'b0;
      o_modulator_tick <= 1'b0;
      o_conversion_tick <= 1'b0;
      o_settled <= 1'b0;
      o_cal_busy <= 1'b0;
    end else begin
      o_modulator_tick <= mod_tick_reg;
      o_conversion_tick <= conv_tick_reg;
      // auto mode counts as settled only once the third-order filter is in use
      if (filt_mode == SDAC_FILT_AUTO) begin
        o_settled <= (auto_stage_reg == 2'h3);
      end else begin
        o_settled <= (settle_reg >= settle_need);
      end
      o_cal_busy <= (state_reg != SDAC_ST_IDLE);
      if (cal_done || (conv_tick_reg && state_reg == SDAC_ST_IDLE && !discard_now)) begin
        irq_reg <= 1'b1;
      end else if (i_result_read) begin
        irq_reg <= 1'b0;
      end
    end
  end
  assign o_adc_interrupt = irq_reg;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_cal_end;
    cal_done;
  endsequence
  sequence s_flag_high;
    ##1 irq_reg;
  endsequence

  property p_trim_split;
    ##1 (o_analog.trim_negative == $past(trim_reg[7])) &&
      (o_analog.trim_magnitude == $past(trim_reg[6:0]));
  endproperty
  a_trim_split: assert property (p_trim_split) else $error("trim split wrong");

  property p_mod_period;
    mod_tick_reg |-> mod_reg == 6'h00 ##1 !mod_tick_reg;
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("modulator tick bad");

  property p_conv_on_mod;
    conv_tick_reg |-> mod_tick_reg && dec_reg == '0;
  endproperty
  a_conv_on_mod: assert property (p_conv_on_mod) else $error("conversion off grid");

  property p_cal_start;
    cal_start |=> state_reg != SDAC_ST_IDLE && cal_count_reg == 4'h0;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("command not started");

  property p_step_len;
    step_end |-> cal_count_reg == 4'h6 && state_reg != SDAC_ST_IDLE;
  endproperty
  a_step_len: assert property (p_step_len) else $error("step length wrong");

  property p_offset_store;
    (step_end && state_reg == SDAC_ST_OFFSET) |=>
      o_offset_correction == 24'h000000 - $past(i_raw_result);
  endproperty
  a_offset_store: assert property (p_offset_store) else $error("offset not stored");

  property p_gain_store;
    (step_end && state_reg == SDAC_ST_GAIN) |=>
      o_gain_correction == SDAC_FULL_SCALE - $past(i_raw_result);
  endproperty
  a_gain_store: assert property (p_gain_store) else $error("gain not stored");

  property p_done_flag;
    s_cal_end |-> s_flag_high;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("flag missing at end");

  property p_auto_first;
    (filt_mode == SDAC_FILT_AUTO && auto_stage_reg == 2'h0 && !i_reset) |=>
      o_analog.discard && o_analog.filter_select == SDAC_FILT_FAST;
  endproperty
  a_auto_first: assert property (p_auto_first) else $error("first not discarded");

  property p_flag_hold;
    (irq_reg && !i_result_read) |=> irq_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");

endmodule : sdac_control

/* File: rtl/sdac_pkg.sv */
// shared constants, field layouts and types for the sigma-delta converter control block
package sdac_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] SDAC_ADDR_CTRL0 = 8'hdc;
  localparam logic [7:0] SDAC_ADDR_CTRL1 = 8'hdd;
  localparam logic [7:0] SDAC_ADDR_TRIM = 8'he6;
  localparam logic [7:0] SDAC_ADDR_ACLK = 8'hf6;
  // values after reset: internal reference enabled at the high level, auto filter
  localparam logic [7:0] SDAC_CTRL0_RESET = 8'h30;
  localparam logic [7:0] SDAC_CTRL1_RESET = 8'h30;
  localparam logic [7:0] SDAC_TRIM_RESET = 8'h00;
  localparam logic [7:0] SDAC_ACLK_RESET = 8'h00;
  // adc_control_zero field positions
  localparam int SDAC_C0_REF_EXT = 6;
  localparam int SDAC_C0_REF_HIGH = 5;
  localparam int SDAC_C0_REF_EN = 4;
  localparam int SDAC_C0_BUFFER = 3;
  localparam int SDAC_C0_BURNOUT = 2;
  // adc_control_one field positions
  localparam int SDAC_C1_FILT_LSB = 4;
  localparam int SDAC_C1_CAL_LSB = 0;
  // offset trim code: sign bit on top, seven bits of magnitude
  localparam int SDAC_TRIM_SIGN = 7;
  // counts
  localparam logic [5:0] SDAC_MOD_LAST = 6'h3f; // fixed divide by 64
  localparam logic [3:0] SDAC_CAL_PERIODS = 4'h7; // conversions per calibration step
  localparam logic [1:0] SDAC_SETTLE_SINC3 = 2'h3;
  localparam logic [1:0] SDAC_SETTLE_SINC2 = 2'h2;
  localparam logic [1:0] SDAC_SETTLE_FAST = 2'h1;
  localparam logic [23:0] SDAC_FULL_SCALE = 24'h7fffff;
  // filter choice
  typedef enum logic [1:0] {
    SDAC_FILT_FAST = 2'h0,
    SDAC_FILT_SINC2 = 2'h1,
    SDAC_FILT_SINC3 = 2'h2,
    SDAC_FILT_AUTO = 2'h3
  } sdac_filter_type;
  // calibration command codes
  typedef enum logic [2:0] {
    SDAC_CAL_NONE = 3'h0,
    SDAC_CAL_SELF_BOTH = 3'h1,
    SDAC_CAL_SELF_OFFSET = 3'h2,
    SDAC_CAL_SELF_GAIN = 3'h3,
    SDAC_CAL_SYS_OFFSET = 3'h4,
    SDAC_CAL_SYS_GAIN = 3'h5,
    SDAC_CAL_SYS_BOTH = 3'h6,
    SDAC_CAL_RSVD = 3'h7
  } sdac_cal_type;
  // calibration sequencer states
  typedef enum logic [2:0] {
    SDAC_ST_IDLE = 3'b001,
    SDAC_ST_OFFSET = 3'b010,
    SDAC_ST_GAIN = 3'b100
  } sdac_state_type;
  // front end input routing during calibration
  localparam logic [1:0] SDAC_IN_NORMAL = 2'h0;
  localparam logic [1:0] SDAC_IN_SELF_ZERO = 2'h1;
  localparam logic [1:0] SDAC_IN_SELF_FULL = 2'h2;
  // special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sdac_sfr_req_type;
  // settings driven into the analog front end
  typedef struct packed {
    logic trim_negative;
    logic [6:0] trim_magnitude;
    logic buffer_enable;
    logic burnout_detect_enable;
    logic ref_external;
    logic ref_enable;
    logic ref_high;
    logic [7:0] current_source_code;
    logic [1:0] cal_input_select;
    logic [1:0] filter_select;
    logic discard;
  } sdac_analog_type;
endpackage : sdac_pkg

/* File: testbench/sdac_control_bench.sv */
// self-checking bench for the sigma-delta converter control block
`timescale 1ns/1ps
module sdac_control_bench;
  import sdac_pkg::*;
  logic clock; // 25 MHz system clock
  logic reset; // synchronous reset, active high
  sdac_sfr_req_type sfr; // register port request
  logic [10:0] ratio; // modulator periods per conversion
  logic [7:0] isrc; // current source code input
  logic chan_change; // channel or gain change pulse
  logic [23:0] raw; // measured code seen by calibration
  logic res_read; // software read of the result
  logic [7:0] rdata;
  sdac_analog_type analog;
  logic mod_tick, conv_tick, settled, cal_busy, irq;
  logic [23:0] off_corr, gain_corr;
  int num_errors; // mismatches so far
  int check_count; // comparisons so far
  int n;
  sdac_control #(.DEC_WIDTH(11)) u_sdac_control (
    .i_clock(clock), .i_reset(reset), .i_sfr(sfr), .i_decimation_ratio(ratio),
    .i_current_source_code(isrc), .i_channel_change(chan_change), .i_raw_result(raw),
    .i_result_read(res_read), .o_sfr_rdata(rdata), .o_analog(analog),
    .o_modulator_tick(mod_tick), .o_conversion_tick(conv_tick), .o_settled(settled),
    .o_cal_busy(cal_busy), .o_adc_interrupt(irq), .o_offset_correction(off_corr),
    .o_gain_correction(gain_corr)
  );
  // free running clock, 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // prints the counts and the verdict, then ends the run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // compare of a multi-bit value, narrow values are zero extended by the caller
  task automatic check_val(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : check_val
  // compare of a single flag
  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %b seen %b", name, exp, got);
      num_errors++;
    end
  endtask : check_bit
  // one-cycle write strobe, launched and released off the falling edge
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    sfr.addr = addr;
    sfr.wdata = data;
    sfr.wr = 1'b1;
    @(negedge clock);
    sfr.wr = 1'b0;
  endtask : sfr_write
  // one-cycle read strobe, data is registered by the edge that takes it
  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clock);
    sfr.addr = addr;
    sfr.rd = 1'b1;
    @(negedge clock);
    sfr.rd = 1'b0;
    check_val("register read", {16'h0000, exp}, {16'h0000, rdata});
  endtask : read_check
  // cycles until the next modulator (sel 0) or conversion (sel 1) pulse, bounded
  task automatic period(input logic sel, output int cycles);
    cycles = 0;
    do begin
      @(negedge clock);
      cycles++;
    end while ((sel ? conv_tick : mod_tick) !== 1'b1 && cycles < 20000);
    if (cycles >= 20000) begin
      $display("[ERR] tick wait expected pulse seen none");
      num_errors++;
      report_and_stop();
    end
  endtask : period
  // runs one calibration command and counts the conversions that it spends
  task automatic run_cal(input logic [2:0] code, input int exp_ticks);
    int ticks;
    int c;
    logic [1:0] exp_sel;
    raw = 24'h001000 + 24'(code);
    exp_sel = (code == 3'h3) ? SDAC_IN_SELF_FULL : SDAC_IN_NORMAL;
    if (code == 3'h1 || code == 3'h2) exp_sel = SDAC_IN_SELF_ZERO;
    period(1'b1, c);
    res_read = 1'b1;
    sfr_write(SDAC_ADDR_CTRL1, {5'h00, code});
    res_read = 1'b0;
    @(negedge clock);
    check_bit("busy during calibration", 1'b1, cal_busy);
    check_val("calibration input", 24'(exp_sel), 24'(analog.cal_input_select));
    if (code == 3'h4) begin
      // a second command while busy is refused, the filter field still lands
      read_check(SDAC_ADDR_CTRL1, 8'h04);
      sfr_write(SDAC_ADDR_CTRL1, 8'h15);
      read_check(SDAC_ADDR_CTRL1, 8'h14);
    end
    ticks = 0;
    c = 0;
    while (irq !== 1'b1 && c < 20000) begin
      @(negedge clock);
      c++;
      if (conv_tick === 1'b1) ticks++;
    end
    if (c >= 20000) begin
      $display("[ERR] calibration wait expected interrupt seen none");
      num_errors++;
      report_and_stop();
    end
    check_val("calibration conversions", 24'(exp_ticks), 24'(ticks));
    check_bit("interrupt at calibration end", 1'b1, irq);
    @(negedge clock);
    check_bit("busy after calibration", 1'b0, cal_busy);
    read_check(SDAC_ADDR_CTRL1, (code == 3'h4) ? 8'h10 : 8'h00);
    if (code == 3'h4 || code == 3'h6) begin
      check_val("offset correction", 24'h0 - raw, off_corr);
    end
    if (code == 3'h5 || code == 3'h6) begin
      check_val("gain correction", SDAC_FULL_SCALE - raw, gain_corr);
    end
    $display("test calibration code %0d done", code);
  endtask : run_cal
  // auto filter schedule: filter in use after k finished conversions
  function automatic logic [1:0] auto_filter(input int k);
    if (k == 1) return SDAC_FILT_FAST;
    if (k == 2) return SDAC_FILT_SINC2;
    return SDAC_FILT_SINC3;
  endfunction : auto_filter
  // channel change under one filter choice: filter in use and conversions to settle
  task automatic settle_check(input logic [1:0] filt, input int exp);
    int k;
    int first;
    int c;
    sfr_write(SDAC_ADDR_CTRL1, {2'b00, filt, 4'h0});
    period(1'b1, c);
    chan_change = 1'b1;
    @(negedge clock);
    chan_change = 1'b0;
    repeat (2) @(negedge clock);
    check_bit("settled after change", 1'b0, settled);
    if (filt == SDAC_FILT_AUTO) begin
      check_bit("first conversion discard", 1'b1, analog.discard);
      check_val("first filter", 24'(SDAC_FILT_FAST), 24'(analog.filter_select));
    end
    first = 0;
    for (k = 1; k <= 4; k++) begin
      period(1'b1, c);
      repeat (3) @(negedge clock);
      if (first == 0 && settled === 1'b1) first = k;
      if (filt == SDAC_FILT_AUTO) begin
        check_bit("later discard", 1'b0, analog.discard);
        check_val("auto filter", 24'(auto_filter(k)), 24'(analog.filter_select));
      end else begin
        check_val("fixed filter", 24'(filt), 24'(analog.filter_select));
      end
    end
    check_val("settling conversions", 24'(exp), 24'(first));
    $display("test filter %0d done", filt);
  endtask : settle_check
  // main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    reset = 1'b1;
    sfr = '0;
    ratio = 11'h001;
    isrc = 8'h00;
    chan_change = 1'b0;
    raw = 24'h000000;
    res_read = 1'b0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    // reset values, an unmapped address reads zero
    read_check(SDAC_ADDR_CTRL0, 8'h30);
    read_check(SDAC_ADDR_CTRL1, 8'h30);
    read_check(SDAC_ADDR_TRIM, 8'h00);
    read_check(SDAC_ADDR_ACLK, 8'h00);
    read_check(8'h10, 8'h00);
    check_bit("reference enable at reset", 1'b1, analog.ref_enable);
    check_bit("reference high at reset", 1'b1, analog.ref_high);
    check_bit("reference external at reset", 1'b0, analog.ref_external);
    $display("test reset values done");
    // external reference, internal one off, buffer and burnout on
    sfr_write(SDAC_ADDR_CTRL0, 8'h4c);
    read_check(SDAC_ADDR_CTRL0, 8'h4c);
    check_bit("reference external", 1'b1, analog.ref_external);
    check_bit("reference enable", 1'b0, analog.ref_enable);
    check_bit("reference high", 1'b0, analog.ref_high);
    check_bit("buffer enable", 1'b1, analog.buffer_enable);
    check_bit("burnout enable", 1'b1, analog.burnout_detect_enable);
    sfr_write(SDAC_ADDR_CTRL0, 8'h30);
    // trim code: both signs, a small and a full magnitude
    sfr_write(SDAC_ADDR_TRIM, 8'h85);
    read_check(SDAC_ADDR_TRIM, 8'h85);
    check_bit("trim sign", 1'b1, analog.trim_negative);
    check_val("trim size", 24'h000005, 24'(analog.trim_magnitude));
    sfr_write(SDAC_ADDR_TRIM, 8'h7f);
    @(negedge clock);
    check_bit("trim sign", 1'b0, analog.trim_negative);
    check_val("trim size", 24'h00007f, 24'(analog.trim_magnitude));
    isrc = 8'ha5;
    repeat (2) @(negedge clock);
    check_val("current source code", 24'h0000a5, 24'(analog.current_source_code));
    $display("test analog settings done");
    // clock chain at divider 2 and ratio 3; the first period after a change is discarded
    ratio = 11'h003;
    sfr_write(SDAC_ADDR_ACLK, 8'h02);
    read_check(SDAC_ADDR_ACLK, 8'h02);
    period(1'b0, n);
    period(1'b0, n);
    check_val("modulator period", 24'd192, 24'(n));
    period(1'b1, n);
    period(1'b1, n);
    check_val("conversion period", 24'd576, 24'(n));
    ratio = 11'h001;
    sfr_write(SDAC_ADDR_ACLK, 8'h00);
    period(1'b1, n);
    period(1'b1, n);
    check_val("conversion period", 24'd64, 24'(n));
    $display("test clock chain done");
    // every command code, with the conversions that each one spends
    run_cal(3'h4, 7);
    run_cal(3'h1, 14);
    run_cal(3'h2, 7);
    run_cal(3'h3, 7);
    run_cal(3'h5, 7);
    run_cal(3'h6, 14);
    // flag holds until the result is read, then clears before the next conversion
    check_bit("flag held", 1'b1, irq);
    res_read = 1'b1;
    @(negedge clock);
    res_read = 1'b0;
    @(negedge clock);
    check_bit("flag after read", 1'b0, irq);
    // reserved code starts nothing; a trim written afterwards leaves the offset correction alone
    sfr_write(SDAC_ADDR_CTRL1, 8'h07);
    repeat (3) @(negedge clock);
    check_bit("busy on reserved code", 1'b0, cal_busy);
    sfr_write(SDAC_ADDR_TRIM, 8'h12);
    repeat (3) @(negedge clock);
    check_val("offset after trim", 24'h0 - raw, off_corr);
    $display("test refused commands done");
    settle_check(SDAC_FILT_FAST, 1);
    settle_check(SDAC_FILT_SINC2, 2);
    settle_check(SDAC_FILT_SINC3, 3);
    settle_check(SDAC_FILT_AUTO, 3);
    report_and_stop();
  end
endmodule : sdac_control_bench
